// File: src/pbs_pkg.sv
package pbs_pkg;
  // ==========================================================
  // geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int DEPTH = 65536;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SLEEP_CYCLES = 2;
  localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_CYCLES - 1);
  localparam logic [1:0] BEAT_ZERO = 2'h0;
  localparam logic [1:0] BEAT_ONE = 2'h1;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

  // sampled bus controls, grouped as they are registered
  typedef struct packed {
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic chip_sel_primary_n;
    logic chip_sel_depth_hi;
    logic chip_sel_depth_n;
    logic byte_write_enable_n;
    logic [3:0] byte_lane_select_n;
    logic all_bytes_write_n;
  } pbs_ctrl_t;

  typedef enum logic [1:0] {
    PBS_IDLE,
    PBS_READ,
    PBS_WRITE
  } pbs_acc_t;

  typedef enum logic [1:0] {
    PBS_AWAKE,
    PBS_ENTER,
    PBS_ASLEEP,
    PBS_EXIT
  } pbs_pwr_t;
endpackage : pbs_pkg

// File: src/pbs_sram.sv
`timescale 1ns/1ps
module pbs_sram
  import pbs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // address and controls
  input wire logic [ADDR_W-1:0] addr,
  input wire pbs_ctrl_t ctrl,
  input wire logic burst_order_sel,
  input wire logic out_enable_n,
  input wire logic sleep_request,
  // shared data pins
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  // status
  output logic sleeping
);
  // ==========================================================
  // storage array
  // word array with byte lanes
  logic [DATA_W-1:0] mem [DEPTH];

  // ==========================================================
  // input registers
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] din_ff;
  pbs_ctrl_t ctrl_ff;
  logic order_ff;
  logic [ADDR_W-1:0] nxt_addr_in;
  logic [DATA_W-1:0] nxt_din;
  pbs_ctrl_t nxt_ctrl;
  logic nxt_order;

  always_comb begin
    nxt_addr_in = addr;
    nxt_din = dq_in;
    nxt_ctrl = ctrl;
    nxt_order = burst_order_sel;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_ff <= ADDR_RST;
      din_ff <= DATA_RST;
      ctrl_ff <= '1;
      order_ff <= 1'b1;
    end else begin
      addr_ff <= nxt_addr_in;
      din_ff <= nxt_din;
      ctrl_ff <= nxt_ctrl;
      order_ff <= nxt_order;
    end
  end

  // ==========================================================
  // decode of the sampled cycle
  logic selected;
  logic proc_take;
  logic ctrl_take;
  logic strobe;
  logic wr_any;
  logic [LANES-1:0] lane_we;
  logic pwr_ok;

  assign selected = !ctrl_ff.chip_sel_primary_n && ctrl_ff.chip_sel_depth_hi &&
                    !ctrl_ff.chip_sel_depth_n;
  // processor strobe masked by primary select
  assign proc_take = !ctrl_ff.proc_addr_strobe_n && !ctrl_ff.chip_sel_primary_n;
  assign ctrl_take = !ctrl_ff.ctrl_addr_strobe_n;
  // only a strobe latches address and selects
  assign strobe = proc_take || ctrl_take;

  always_comb begin
    if (!ctrl_ff.all_bytes_write_n) begin
      lane_we = '1;
    end else if (!ctrl_ff.byte_write_enable_n) begin
      lane_we = ~ctrl_ff.byte_lane_select_n;
    end else begin
      lane_we = '0;
    end
    wr_any = |lane_we;
  end

  // ==========================================================
  // access state, address register and burst counter
  pbs_acc_t acc_ff, nxt_acc;
  logic [ADDR_W-1:0] base_ff, nxt_base;
  logic [1:0] beat_ff, nxt_beat;
  logic first_ff, nxt_first;
  logic [1:0] low_bits;
  logic [ADDR_W-1:0] cur_addr;
  logic do_write;
  logic do_read;

  // linear order: add beat modulo four
  assign low_bits = order_ff ? (base_ff[1:0] ^ beat_ff) : 2'(base_ff[1:0] + beat_ff);
  assign cur_addr = {base_ff[ADDR_W-1:2], low_bits};

  always_comb begin
    nxt_acc = acc_ff;
    nxt_base = base_ff;
    nxt_beat = beat_ff;
    nxt_first = 1'b0;
    do_write = 1'b0;
    do_read = 1'b0;
    if (!pwr_ok) begin
      nxt_acc = PBS_IDLE;
    end else if (strobe && !selected) begin
      nxt_acc = PBS_IDLE;
    end else if (proc_take) begin
      // first cycle loads address, ignores write and advance
      // processor strobe always begins a read
      // read on strobe even with write controls active
      nxt_acc = PBS_READ;
      nxt_base = addr_ff;
      nxt_beat = BEAT_ZERO;
      nxt_first = (acc_ff == PBS_IDLE);
      do_read = 1'b1;
    end else if (ctrl_take) begin
      nxt_base = addr_ff;
      nxt_beat = BEAT_ZERO;
      nxt_first = (acc_ff == PBS_IDLE);
      if (wr_any) begin
        nxt_acc = PBS_WRITE;
        do_write = 1'b1;
      end else begin
        nxt_acc = PBS_READ;
        do_read = 1'b1;
      end
    end else if (acc_ff != PBS_IDLE) begin
      // advance low steps counter in reads and writes
      if (!ctrl_ff.burst_advance_n) begin
        nxt_beat = 2'(beat_ff + BEAT_ONE);
      end
      if (wr_any) begin
        nxt_acc = PBS_WRITE;
        do_write = 1'b1;
      end else begin
        nxt_acc = PBS_READ;
        do_read = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_ff <= PBS_IDLE;
      base_ff <= ADDR_RST;
      beat_ff <= BEAT_ZERO;
      first_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      base_ff <= nxt_base;
      beat_ff <= nxt_beat;
      first_ff <= nxt_first;
    end
  end

  // write address: new address for controller write, burst address otherwise
  logic [ADDR_W-1:0] wr_addr;
  assign wr_addr = ctrl_take ? addr_ff : cur_addr;
  logic [ADDR_W-1:0] rd_addr;
  assign rd_addr = strobe ? addr_ff : cur_addr;

  // ==========================================================
  // array write and output register
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;

  always_ff @(posedge clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (do_write && lane_we[i]) begin
        mem[wr_addr][i*8 +: 8] <= din_ff[i*8 +: 8];
      end
    end
  end

  // read data through the output register
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (do_read) begin
      nxt_rdata = mem[rd_addr];
      nxt_rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= DATA_RST;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ==========================================================
  // sleep sequencing
  pbs_pwr_t pwr_ff, nxt_pwr;
  logic [1:0] scnt_ff, nxt_scnt;

  // two clocks to enter and two to leave
  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_scnt = BEAT_ZERO;
    unique case (pwr_ff)
      PBS_AWAKE: if (sleep_request) nxt_pwr = PBS_ENTER;
      PBS_ENTER: begin
        nxt_scnt = 2'(scnt_ff + BEAT_ONE);
        if (scnt_ff == SLEEP_CNT_LAST) nxt_pwr = PBS_ASLEEP;
      end
      PBS_ASLEEP: if (!sleep_request) nxt_pwr = PBS_EXIT;
      PBS_EXIT: begin
        nxt_scnt = 2'(scnt_ff + BEAT_ONE);
        if (scnt_ff == SLEEP_CNT_LAST) nxt_pwr = PBS_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_ff <= PBS_AWAKE;
      scnt_ff <= BEAT_ZERO;
    end else begin
      pwr_ff <= nxt_pwr;
      scnt_ff <= nxt_scnt;
    end
  end

  assign pwr_ok = (pwr_ff == PBS_AWAKE) && !sleep_request;
  assign sleeping = (pwr_ff != PBS_AWAKE);

  // ==========================================================
  // data drivers
  // registered data drives the bus when enabled
  // first cycle after selection from idle stays off
  assign dq_out = rdata_ff;
  // a deselect or a write seen in the input registers shuts the drivers in that
  // same cycle, before the access state has caught up one edge later
  assign dq_oe_n = !(rvalid_ff && !first_ff && (acc_ff == PBS_READ) && !out_enable_n &&
                     !(strobe && !selected) && !do_write);

  // ==========================================================
  // checks
  a_write_no_drive:
    assert property (@(posedge clk) disable iff (!rst_n)
      (acc_ff == PBS_WRITE) |-> dq_oe_n) else $error("drivers on in write");
  a_oe_gates_bus:
    assert property (@(posedge clk) disable iff (!rst_n)
      out_enable_n |-> dq_oe_n) else $error("drivers on with oe high");
  a_proc_reads:
    assert property (@(posedge clk) disable iff (!rst_n)
      (proc_take && selected && pwr_ok) |=> (acc_ff == PBS_READ))
      else $error("processor strobe did not read");
  a_deselect_off:
    assert property (@(posedge clk) disable iff (!rst_n)
      (strobe && !selected) |-> dq_oe_n) else $error("drivers on after deselect");
  a_beat_step:
    assert property (@(posedge clk) disable iff (!rst_n)
      (!strobe && acc_ff != PBS_IDLE && pwr_ok && !ctrl_ff.burst_advance_n)
      |=> beat_ff == 2'($past(beat_ff) + 2'h1)) else $error("burst did not advance");
  a_sleep_entry:
    assert property (@(posedge clk) disable iff (!rst_n)
      (pwr_ff == PBS_AWAKE && sleep_request) |=> (pwr_ff == PBS_ENTER) ##2
      (pwr_ff == PBS_ASLEEP)) else $error("sleep entry timing");
  a_sleep_drop:
    assert property (@(posedge clk) disable iff (!rst_n)
      sleep_request |=> acc_ff == PBS_IDLE) else $error("access kept in sleep");
  a_first_off:
    assert property (@(posedge clk) disable iff (!rst_n)
      first_ff |-> dq_oe_n) else $error("drivers on in first cycle");
endmodule : pbs_sram

// File: tb/pbs_master.sv
`timescale 1ns/1ps
// ==========================================
// bus master driving the memory
module pbs_master
  import pbs_pkg::*;
(
  // clock
  input wire logic clk,
  // bus toward the memory
  output logic [ADDR_W-1:0] addr,
  output pbs_ctrl_t ctrl,
  output logic out_enable_n,
  output logic sleep_request,
  output logic [DATA_W-1:0] dq
);
  // selected, no strobe, no write: a suspended beat
  localparam logic [11:0] IDLE = 12'hEBF;
  // deselected through the primary select
  localparam logic [11:0] OFF = 12'hFBF;

  // quiet bus at time zero
  initial begin
    addr = '0;
    ctrl = pbs_ctrl_t'(IDLE);
    out_enable_n = 1'b1;
    sleep_request = 1'b0;
    dq = '0;
  end

  // one bus cycle, launched at the falling edge
  task automatic cyc(input logic [11:0] c, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    logic wr;
    wr = !c[0] || (!c[5] && c[4:1] != 4'hF);
    @(negedge clk);
    ctrl = pbs_ctrl_t'(c);
    addr = a;
    out_enable_n = wr;
    // released lines toggle so stale data never looks valid
    dq = wr ? d : ~dq;
  endtask : cyc

  task automatic idle(input int n);
    repeat (n) cyc(IDLE, addr, dq);
  endtask : idle

  task automatic doze(input int n);
    cyc(OFF, addr, dq);
    sleep_request = 1'b1;
    repeat (n) cyc(OFF, addr, dq);
  endtask : doze

  task automatic wake;
    sleep_request = 1'b0;
    repeat (SLEEP_CYCLES + 1) cyc(OFF, addr, dq);
  endtask : wake
endmodule : pbs_master

// File: tb/pipelined_burst_sync_sram_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench
module pipelined_burst_sync_sram_tb_top
  import pbs_pkg::*;
;
  logic clk;
  logic rst_n;
  logic burst_order_sel;
  logic [ADDR_W-1:0] addr;
  pbs_ctrl_t ctrl;
  logic out_enable_n;
  logic sleep_request;
  logic [DATA_W-1:0] dq_in;
  logic [DATA_W-1:0] dq_out;
  logic dq_oe_n;
  logic sleeping;
  int bad_count;
  int samples_checked;
  logic [DATA_W-1:0] mem [int];
  logic [ADDR_W-1:0] base;
  int last;

  pbs_sram pbs_sram_i (.clk(clk), .rst_n(rst_n), .addr(addr), .ctrl(ctrl),
    .burst_order_sel(burst_order_sel), .out_enable_n(out_enable_n),
    .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .sleeping(sleeping));
  pbs_master pbs_master_i (.clk(clk), .addr(addr), .ctrl(ctrl),
    .out_enable_n(out_enable_n), .sleep_request(sleep_request), .dq(dq_in));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // write cycle with prefix p, mirrored in the model
  task automatic wr(input logic [5:0] p, input int wa, input logic [31:0] d,
                    input logic [5:0] w);
    pbs_master_i.cyc({p, w}, wa[15:0], d);
    for (int i = 0; i < 4; i++) begin
      if (!w[0] || (!w[5] && !w[i+1])) mem[wa][8*i+:8] = d[8*i+:8];
    end
  endtask : wr

  // start a read, then suspend long enough for the pipeline to settle
  task automatic rd(input int ra);
    pbs_master_i.cyc(12'hABF, ra[15:0], '0);
    pbs_master_i.idle(3);
  endtask : rd

  // watchdog, far beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // ==========================================
  // main sequence
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    burst_order_sel = 1'b1;
    void'($urandom(32'hC351));
    repeat (10) @(posedge clk);
    @(negedge clk);
    check(dq_out, DATA_RST);
    check({31'h0, dq_oe_n}, 32'h1);
    check({31'h0, sleeping}, 32'h0);
    rst_n = 1'b1;
    // order is free here: single-beat writes never use the counter
    burst_order_sel = 1'($urandom);
    $display("reset test done");
    // full words, byte writes, then a two-clock processor write
    base = 16'($urandom) & 16'hFFFC;
    for (int i = 0; i < 4; i++) wr(6'b101010, base + i, $urandom, 6'h3E);
    for (int i = 0; i < 6; i++) begin
      wr(6'b101010, base + $urandom % 4, $urandom, {1'b0, 4'($urandom), 1'b1});
    end
    pbs_master_i.cyc(12'h6BF, base + 2, '0);
    wr(6'b111010, base + 2, $urandom, {1'b0, 4'($urandom), 1'b1});
    // accepted processor strobe with global write low stays a read
    pbs_master_i.cyc(12'h6BE, base + 1, $urandom);
    pbs_master_i.idle(3);
    check(dq_out, mem[base + 1]);
    $display("write test done");
    // every start in both orders
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        burst_order_sel = m[0];
        rd(base + s);
        check(dq_out, mem[base + s]);
        check({31'h0, dq_oe_n}, 32'h0);
        for (int b = 1; b < 4; b++) begin
          pbs_master_i.cyc(12'hCBF, base, '0);
          pbs_master_i.idle(3);
          last = base + (m ? (s ^ b) : ((s + b) % 4));
          check(dq_out, mem[last]);
        end
      end
    end
    $display("burst test done");
    // output enable acts without a clock
    @(negedge clk);
    pbs_master_i.out_enable_n = 1'b1;
    #1 check({31'h0, dq_oe_n}, 32'h1);
    @(negedge clk);
    pbs_master_i.out_enable_n = 1'b0;
    #1 check({31'h0, dq_oe_n}, 32'h0);
    // processor strobe with primary select high changes nothing
    pbs_master_i.cyc(12'h7BF, base ^ 16'h0100, '0);
    pbs_master_i.idle(3);
    check(dq_out, mem[last]);
    check({31'h0, dq_oe_n}, 32'h0);
    // strobe with either depth select wrong deselects
    pbs_master_i.cyc({4'hA, {2{1'($urandom)}}, 6'h3F}, base, '0);
    pbs_master_i.idle(1);
    check({31'h0, dq_oe_n}, 32'h1);
    $display("select test done");
    pbs_master_i.doze(4);
    check({31'h0, sleeping}, 32'h1);
    pbs_master_i.wake();
    check({31'h0, sleeping}, 32'h0);
    // first read after sleep starts from idle: drivers stay off one cycle
    pbs_master_i.cyc(12'hABF, base + 3, '0);
    pbs_master_i.idle(2);
    check({31'h0, dq_oe_n}, 32'h1);
    pbs_master_i.idle(1);
    check({31'h0, dq_oe_n}, 32'h0);
    check(dq_out, mem[base + 3]);
    $display("sleep test done");
    summarize();
  end
endmodule : pipelined_burst_sync_sram_tb_top
